// *** shared/lin_sci_params.svh ***
// Register offsets, field positions, reset values and timing counts of the LIN serial receiver
`ifndef LIN_SCI_PARAMS_SVH
`define LIN_SCI_PARAMS_SVH

// Register offsets
`define LS_ADDR_STATUS    3'h0
`define LS_ADDR_CTRL_ONE  3'h1
`define LS_ADDR_CTRL_TWO  3'h2
`define LS_ADDR_DATA      3'h3
`define LS_ADDR_BAUD      3'h4
`define LS_ADDR_RX_FINE   3'h5
`define LS_ADDR_TX_FINE   3'h6
`define LS_ADDR_LIN_CTRL  3'h7

// Reset values
`define LS_STATUS_RESET   8'hC0
`define LS_CTRL_ONE_RESET 8'h00
`define LS_CTRL_TWO_RESET 8'h00
`define LS_BAUD_RESET     8'h00
`define LS_FINE_RESET     8'h00
`define LS_LIN_CTRL_RESET 8'h00

// First control register fields
`define LS_C1_R8          7
`define LS_C1_NINE_BITS   4
`define LS_C1_WAKE        3
`define LS_C1_PCE         2
`define LS_C1_PIE         0

// Second control register fields
`define LS_C2_RIE         5
`define LS_C2_ILIE        4
`define LS_C2_RE          2
`define LS_C2_MUTE        1

// Baud select fields
`define LS_BAUD_PR_HI     7
`define LS_BAUD_PR_LO     6
`define LS_BAUD_TX_HI     5
`define LS_BAUD_TX_LO     3
`define LS_BAUD_RX_HI     2
`define LS_BAUD_RX_LO     0

// LIN control fields
`define LS_LC_LIN_EN      7
`define LS_LC_SLAVE       6
`define LS_LC_HDM         5
`define LS_LC_SYNC_LOCK   1
`define LS_LC_HDR_DETECT  0

// Common prescaler divisors
`define LS_PR_DIV_0       4'h1
`define LS_PR_DIV_1       4'h3
`define LS_PR_DIV_2       4'h4
`define LS_PR_DIV_3       4'hD

// Timing counts, in sample ticks or bit times, and the sync byte
`define LS_SAMPLE_LAST    4'hF
`define LS_VOTE_FIRST     4'h7
`define LS_VOTE_LAST      4'h9
`define LS_IDLE_TICKS_8   8'hA0
`define LS_IDLE_TICKS_9   8'hB0
`define LS_HDR_TIMEOUT    8'h30
`define LS_SYNC_BYTE      8'h55

`endif

// *** shared/lin_sci_pkg.sv ***
// Types shared by the LIN serial receiver modules
package lin_sci_pkg;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic [8:0] data;
    logic       frame_err;
    logic       noise;
    logic       brk;
  } rx_char_t;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_BITS  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_phase_t;

  typedef enum logic [2:0] {
    HDR_IDLE = 3'b001,
    HDR_SYNC = 3'b010,
    HDR_ID   = 3'b100
  } hdr_state_t;

  typedef struct packed {
    logic [3:0] pre_cnt;
    logic [6:0] pow_cnt;
    logic [7:0] fine_cnt;
    logic       tick;
  } baud_state_t;

  typedef struct packed {
    rx_phase_t  phase;
    logic [3:0] sub;
    logic [3:0] bit_idx;
    logic [8:0] shift;
    logic [2:0] votes;
    logic       noise_acc;
    logic       any_one;
    logic       seen_high;
    logic [7:0] idle_cnt;
    logic       idle_armed;
    logic       char_valid;
    rx_char_t   char_out;
    logic       idle_seen;
  } rx_state_t;

  typedef struct packed {
    logic       rxd_meta;
    logic       rxd_sync;
    logic [7:0] rd_data;
    logic       tdre;
    logic       tc;
    logic       rx_full;
    logic       idle;
    logic       header_error;
    logic       noise;
    logic       framing;
    logic       parity;
    logic [7:0] ctrl_one;
    logic [7:0] ctrl_two;
    logic [7:0] baud;
    logic [7:0] rx_fine;
    logic [7:0] tx_fine;
    logic       lin_en;
    logic       lin_slave;
    logic       hdm;
    logic       sync_lock;
    logic       hdr_detect;
    logic [7:0] data;
    logic       status_seen;
    hdr_state_t hdr;
    logic [7:0] hdr_bits;
    logic [3:0] hdr_sub;
    logic [3:0] tx_sub;
    logic       tx_bit_tick;
    logic       rx_irq;
    logic       parity_irq;
  } top_state_t;

endpackage

// *** verilog/lin_baud_gen.sv ***
// Cascaded enable counters giving one direction's sample tick
`timescale 1ns/100ps
`include "lin_sci_params.svh"
module lin_baud_gen (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Rate selection
  input  wire logic [1:0] prescale_sel,
  input  wire logic [2:0] pow_sel,
  input  wire logic [7:0] fine_div,
  // Sample tick, sixteen per bit
  output logic            tick
);
  import lin_sci_pkg::*;

  baud_state_t s;
  baud_state_t n;
  logic [3:0]  pre_max;
  logic [7:0]  pow_span;
  logic [6:0]  pow_max;
  logic        pre_hit;
  logic        pow_hit;

  always_comb begin
    n = s;
    n.tick = 1'b0;
    case (prescale_sel)
      2'h0:    pre_max = 4'(`LS_PR_DIV_0 - 4'h1);
      2'h1:    pre_max = 4'(`LS_PR_DIV_1 - 4'h1);
      2'h2:    pre_max = 4'(`LS_PR_DIV_2 - 4'h1);
      default: pre_max = 4'(`LS_PR_DIV_3 - 4'h1);
    endcase
    pow_span = 8'((8'h01 << pow_sel) - 8'h01);
    pow_max  = pow_span[6:0];
    pre_hit = s.pre_cnt >= pre_max;
    pow_hit = pre_hit && (s.pow_cnt >= pow_max);
    n.pre_cnt = pre_hit ? 4'h0 : 4'(s.pre_cnt + 4'h1);
    if (pre_hit) begin
      n.pow_cnt = pow_hit ? 7'h00 : 7'(s.pow_cnt + 7'h01);
    end
    if (pow_hit) begin
      if (fine_div == 8'h00) begin
        n.tick = 1'b1;
      end else if (s.fine_cnt >= 8'(fine_div - 8'h01)) begin
        n.fine_cnt = 8'h00;
        n.tick     = 1'b1;
      end else begin
        n.fine_cnt = 8'(s.fine_cnt + 8'h01);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick = s.tick;
endmodule

// *** verilog/lin_rx_frame.sv ***
// Oversampling character receiver with noise, framing, break and idle detection
`timescale 1ns/100ps
`include "lin_sci_params.svh"
module lin_rx_frame (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // Line and rate
  input  wire logic                  sample_tick,
  input  wire logic                  rxd,
  input  wire logic                  nine_bits,
  // Results
  output logic                       char_valid,
  output lin_sci_pkg::rx_char_t      char_out,
  output logic                       idle_seen
);
  import lin_sci_pkg::*;

  rx_state_t  s;
  rx_state_t  n;
  logic       bit_val;
  logic       bit_noisy;
  logic [3:0] last_idx;
  logic [7:0] idle_ticks;

  always_comb begin
    n = s;
    n.char_valid = 1'b0;
    n.idle_seen  = 1'b0;
    bit_val   = (s.votes[0] & s.votes[1]) | (s.votes[0] & s.votes[2]) | (s.votes[1] & s.votes[2]);
    bit_noisy = !((s.votes == 3'h0) || (s.votes == 3'h7));
    last_idx   = nine_bits ? 4'h8 : 4'h7;
    idle_ticks = nine_bits ? `LS_IDLE_TICKS_9 : `LS_IDLE_TICKS_8;
    if (sample_tick) begin
      if (s.phase != RX_IDLE) begin
        n.sub = 4'(s.sub + 4'h1);
        if (s.sub >= `LS_VOTE_FIRST && s.sub <= `LS_VOTE_LAST) begin
          n.votes = {s.votes[1:0], rxd};
        end
      end
      case (s.phase)
        RX_IDLE: begin
          // A start edge only counts after the line was seen high
          if (!rxd && s.seen_high) begin
            n.phase     = RX_START;
            n.sub       = 4'h1;
            n.noise_acc = 1'b0;
            n.any_one   = 1'b0;
            n.idle_cnt  = 8'h00;
          end else if (rxd) begin
            n.seen_high = 1'b1;
            if (s.idle_armed) begin
              n.idle_cnt = 8'(s.idle_cnt + 8'h01);
              if (s.idle_cnt == 8'(idle_ticks - 8'h01)) begin
                n.idle_seen  = 1'b1;
                n.idle_armed = 1'b0;
              end
            end
          end else begin
            n.idle_cnt = 8'h00;
          end
        end
        RX_START: begin
          if (s.sub == `LS_SAMPLE_LAST) begin
            n.noise_acc = bit_noisy;
            n.bit_idx   = 4'h0;
            n.phase     = bit_val ? RX_IDLE : RX_BITS;
          end
        end
        RX_BITS: begin
          if (s.sub == `LS_SAMPLE_LAST) begin
            n.shift[s.bit_idx] = bit_val;
            n.any_one   = s.any_one | bit_val;
            n.noise_acc = s.noise_acc | bit_noisy;
            n.bit_idx   = 4'(s.bit_idx + 4'h1);
            if (s.bit_idx == last_idx) begin
              n.phase = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (s.sub == `LS_SAMPLE_LAST) begin
            n.phase              = RX_IDLE;
            n.char_valid         = 1'b1;
            n.char_out.data      = nine_bits ? s.shift : {1'b0, s.shift[7:0]};
            n.char_out.frame_err = !bit_val && s.any_one;
            n.char_out.brk       = !bit_val && !s.any_one;
            n.char_out.noise     = s.noise_acc | bit_noisy;
            n.seen_high          = bit_val;
            n.idle_armed         = 1'b1;
            n.idle_cnt           = 8'h00;
          end
        end
        default: begin
          n.phase = RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s       <= '0;
      s.phase <= RX_IDLE;
    end else begin
      s <= n;
    end
  end

  assign char_valid = s.char_valid;
  assign char_out   = s.char_out;
  assign idle_seen  = s.idle_seen;
endmodule

// *** verilog/lin_sci_receiver.sv ***
// LIN capable serial receiver: registers, baud generation, header errors and muting
// Behaviour
// - Header error on locked corrupt sync, header timeout, or header field overrun.
// - Receive interrupt when header error set and receive interrupt enable is 1.
// - Outside a header the header error flag reports receive overrun.
// - Noise flag as plain mode in LIN master; meaningless in LIN slave.
// - Slave framing error only if stop is 0 and some bit is 1.
// - Slave break sets no framing error; header detect flag instead if mode 0.
// - Framing error clears by status access then data read.
// - Identifier parity error flag, its interrupt, cleared by status then data read.
// - First control bit 2 enables identifier parity checking.
// - Each direction: clock over 16, common prescaler, power-of-two divider.
// - Nonzero fine prescaler further divides that direction's rate.
// - Fine prescalers reset to zero, leaving extended generation inactive.
// - Mute sleeps the receiver: no status bits set, no receive interrupts; here a pending header timeout still sets header error.
// - Muted receiver wakes on idle line or address mark per wake bit.
// - Idle wake clears mute without setting the idle flag.
// - Address mark wake clears mute, sets receive full, delivers the word.
// - Status register resets to C0h.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`include "lin_sci_params.svh"
module lin_sci_receiver (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // Register port
  input  wire lin_sci_pkg::reg_req_t reg_req,
  output logic [7:0]                 rd_data,
  // Serial line
  input  wire logic                  rxd,
  output logic                       tx_bit_tick,
  // Interrupt requests
  output logic                       rx_irq,
  output logic                       parity_irq
);
  import lin_sci_pkg::*;

  top_state_t s;
  top_state_t n;
  logic       rx_tick;
  logic       tx_tick;
  logic       char_valid;
  rx_char_t   rx_char;
  logic       idle_seen;
  logic       muted;
  logic       slave_mode;
  logic       msb;
  logic       accept;

  function automatic logic [1:0] id_parity(input logic [5:0] id);
    id_parity = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4]};
  endfunction

  lin_baud_gen rx_baud (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .prescale_sel (s.baud[`LS_BAUD_PR_HI:`LS_BAUD_PR_LO]),
    .pow_sel      (s.baud[`LS_BAUD_RX_HI:`LS_BAUD_RX_LO]),
    .fine_div     (s.rx_fine),
    .tick         (rx_tick)
  );

  lin_baud_gen tx_baud (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .prescale_sel (s.baud[`LS_BAUD_PR_HI:`LS_BAUD_PR_LO]),
    .pow_sel      (s.baud[`LS_BAUD_TX_HI:`LS_BAUD_TX_LO]),
    .fine_div     (s.tx_fine),
    .tick         (tx_tick)
  );

  lin_rx_frame rx_frame (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .sample_tick (rx_tick),
    .rxd         (s.rxd_sync),
    .nine_bits   (s.ctrl_one[`LS_C1_NINE_BITS]),
    .char_valid  (char_valid),
    .char_out    (rx_char),
    .idle_seen   (idle_seen)
  );

  always_comb begin
    n = s;
    n.rxd_meta    = rxd;
    n.rxd_sync    = s.rxd_meta;
    n.rd_data     = 8'h00;
    n.tx_bit_tick = 1'b0;
    muted      = s.ctrl_two[`LS_C2_MUTE];
    slave_mode = s.lin_en && s.lin_slave;
    msb        = s.ctrl_one[`LS_C1_NINE_BITS] ? rx_char.data[8] : rx_char.data[7];
    accept     = 1'b0;

    // Register reads; unmapped offsets cannot occur, all eight are decoded
    if (reg_req.rd) begin
      case (reg_req.addr)
        `LS_ADDR_STATUS: begin
          n.rd_data = {s.tdre, s.tc, s.rx_full, s.idle,
                       s.header_error, s.noise, s.framing, s.parity};
          n.status_seen = 1'b1;
        end
        `LS_ADDR_CTRL_ONE: n.rd_data = {s.ctrl_one[7:2], 1'b0, s.ctrl_one[0]};
        `LS_ADDR_CTRL_TWO: n.rd_data = s.ctrl_two;
        `LS_ADDR_DATA: begin
          n.rd_data = s.data;
          if (s.status_seen) begin
            n.status_seen = 1'b0;
            n.rx_full     = 1'b0;
            n.idle        = 1'b0;
            n.noise       = 1'b0;
            n.framing     = 1'b0;
            n.parity      = 1'b0;
            if (!s.sync_lock) begin
              n.header_error = 1'b0;
            end
          end
        end
        `LS_ADDR_BAUD:    n.rd_data = s.baud;
        `LS_ADDR_RX_FINE: n.rd_data = s.rx_fine;
        `LS_ADDR_TX_FINE: n.rd_data = s.tx_fine;
        default: n.rd_data = {s.lin_en, s.lin_slave, s.hdm, 3'h0, s.sync_lock, s.hdr_detect};
      endcase
    end

    // Register writes; status and data are not writable here
    if (reg_req.wr) begin
      case (reg_req.addr)
        `LS_ADDR_CTRL_ONE: n.ctrl_one = {s.ctrl_one[`LS_C1_R8], reg_req.wdata[6:2],
                                         1'b0, reg_req.wdata[0]};
        `LS_ADDR_CTRL_TWO: n.ctrl_two = reg_req.wdata;
        `LS_ADDR_BAUD:     n.baud     = reg_req.wdata;
        `LS_ADDR_RX_FINE:  n.rx_fine  = reg_req.wdata;
        `LS_ADDR_TX_FINE:  n.tx_fine  = reg_req.wdata;
        `LS_ADDR_LIN_CTRL: begin
          n.lin_en    = reg_req.wdata[`LS_LC_LIN_EN];
          n.lin_slave = reg_req.wdata[`LS_LC_SLAVE];
          n.hdm       = reg_req.wdata[`LS_LC_HDM];
          // Clearing the lock releases the header
          if (!reg_req.wdata[`LS_LC_SYNC_LOCK] && s.sync_lock) begin
            n.sync_lock = 1'b0;
            n.hdr       = HDR_IDLE;
          end
          if (!reg_req.wdata[`LS_LC_HDR_DETECT]) begin
            n.hdr_detect = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Hardware events follow software so a hardware update beats a same-cycle software read or write
    if (char_valid && s.ctrl_two[`LS_C2_RE]) begin
      if (!muted) begin
        accept = 1'b1;
      end else if (s.ctrl_one[`LS_C1_WAKE] && msb) begin
        accept = 1'b1;
        n.ctrl_two[`LS_C2_MUTE] = 1'b0;
      end
      if (accept) begin
        if (rx_char.brk && s.lin_en) begin
          if (!s.hdm) begin
            n.hdr_detect = 1'b1;
          end
          if (!s.sync_lock) begin
            n.hdr      = HDR_SYNC;
            n.hdr_bits = 8'h00;
            n.hdr_sub  = 4'h0;
          end
        end
        if (s.rx_full) begin
          n.header_error = 1'b1;
        end else if (!(rx_char.brk && slave_mode)) begin
          n.rx_full  = 1'b1;
          n.data     = rx_char.data[7:0];
          n.ctrl_one[`LS_C1_R8] = rx_char.data[8];
          if (rx_char.noise && !slave_mode) begin
            n.noise = 1'b1;
          end
          if (rx_char.frame_err || (rx_char.brk && !slave_mode)) begin
            n.framing = 1'b1;
          end
        end
        if (!rx_char.brk && s.lin_en) begin
          case (s.hdr)
            HDR_SYNC: begin
              if (!s.sync_lock && rx_char.data[7:0] != `LS_SYNC_BYTE) begin
                n.sync_lock    = 1'b1;
                n.header_error = 1'b1;
              end else if (!s.sync_lock) begin
                n.hdr = HDR_ID;
              end
            end
            HDR_ID: begin
              if (s.ctrl_one[`LS_C1_PCE] &&
                  id_parity(rx_char.data[5:0]) != rx_char.data[7:6]) begin
                n.parity = 1'b1;
              end
              n.hdr = HDR_IDLE;
            end
            default: begin
            end
          endcase
        end
      end
    end

    if (idle_seen && s.ctrl_two[`LS_C2_RE]) begin
      if (muted) begin
        if (!s.ctrl_one[`LS_C1_WAKE]) begin
          n.ctrl_two[`LS_C2_MUTE] = 1'b0;
        end
      end else begin
        n.idle = 1'b1;
      end
    end

    if (s.hdr != HDR_IDLE && !s.sync_lock && rx_tick) begin
      n.hdr_sub = 4'(s.hdr_sub + 4'h1);
      if (s.hdr_sub == `LS_SAMPLE_LAST) begin
        n.hdr_bits = 8'(s.hdr_bits + 8'h01);
        if (s.hdr_bits == 8'(`LS_HDR_TIMEOUT - 8'h01)) begin
          n.header_error = 1'b1;
          n.hdr          = HDR_IDLE;
        end
      end
    end

    // Transmit bit rate for the transmit shifter outside
    if (tx_tick) begin
      n.tx_sub = 4'(s.tx_sub + 4'h1);
      n.tx_bit_tick = (s.tx_sub == `LS_SAMPLE_LAST);
    end

    n.rx_irq = !n.ctrl_two[`LS_C2_MUTE] &&
               ((n.ctrl_two[`LS_C2_RIE] && (n.rx_full || n.header_error)) ||
                (n.ctrl_two[`LS_C2_ILIE] && n.idle));
    n.parity_irq = !n.ctrl_two[`LS_C2_MUTE] && n.ctrl_one[`LS_C1_PIE] && n.parity;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      {s.tdre, s.tc, s.rx_full, s.idle, s.header_error, s.noise, s.framing, s.parity}
        <= `LS_STATUS_RESET;
      s.ctrl_one <= `LS_CTRL_ONE_RESET;
      s.ctrl_two <= `LS_CTRL_TWO_RESET;
      s.baud     <= `LS_BAUD_RESET;
      s.rx_fine  <= `LS_FINE_RESET;
      s.tx_fine  <= `LS_FINE_RESET;
      {s.lin_en, s.lin_slave, s.hdm} <= 3'h0;
      s.rxd_meta <= 1'b1;
      s.rxd_sync <= 1'b1;
      s.hdr      <= HDR_IDLE;
    end else begin
      s <= n;
    end
  end

  assign rd_data     = s.rd_data;
  assign tx_bit_tick = s.tx_bit_tick;
  assign rx_irq      = s.rx_irq;
  assign parity_irq  = s.parity_irq;
endmodule

// *** dv/lin_bus_node.sv ***
// Serial bus node model driving the receive line
`timescale 1ns/100ps
module lin_bus_node (
  // Clock
  input  wire logic ref_clk,
  // Bus line, recessive high through the pull-up
  output logic      rxd
);
  initial rxd = 1'b1;

  // One level for a number of bit times
  task automatic hold_line(input logic level, input int bits, input int bit_clks);
    rxd <= level;
    repeat (bits * bit_clks) @(posedge ref_clk);
  endtask

  // Start, eight bits LSB first, stop, then released
  task automatic send_char(input logic [7:0] value, input logic stop, input int bit_clks);
    int i;
    @(posedge ref_clk);
    hold_line(1'b0, 1, bit_clks);
    for (i = 0; i < 8; i++) begin
      hold_line(value[i], 1, bit_clks);
    end
    hold_line(stop, 1, bit_clks);
    rxd <= 1'b1;
  endtask

  // Thirteen dominant bits, then one recessive delimiter bit
  task automatic send_break(input int bit_clks);
    @(posedge ref_clk);
    hold_line(1'b0, 13, bit_clks);
    hold_line(1'b1, 1, bit_clks);
  endtask
endmodule

// *** dv/lin_sci_receiver_props.sv ***
// Port checker for the LIN serial receiver
`timescale 1ns/100ps
`include "lin_sci_params.svh"
module lin_sci_receiver_props (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // Register port
  input  wire lin_sci_pkg::reg_req_t reg_req,
  input  wire logic [7:0]            rd_data,
  // Line and requests
  input  wire logic                  rxd,
  input  wire logic                  tx_bit_tick,
  input  wire logic                  rx_irq,
  input  wire logic                  parity_irq
);
  import lin_sci_pkg::*;
  logic [7:0] c1, c2, baud, rx_fine, tx_fine;
  logic [1:0] settle;
  logic       first;
  int         gap;
  int         exp_gap;
  int         pr;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Shadow of software-only fields
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {c1, c2, baud, rx_fine, tx_fine} <= '0;
      settle <= 2'd0;
      first  <= 1'b1;
      gap    <= 0;
    end else begin
      first <= 1'b0;
      gap   <= tx_bit_tick ? 1 : gap + 1;
      if (reg_req.wr) begin
        case (reg_req.addr)
          `LS_ADDR_CTRL_ONE: c1 <= reg_req.wdata;
          `LS_ADDR_CTRL_TWO: c2 <= reg_req.wdata;
          `LS_ADDR_BAUD:     baud <= reg_req.wdata;
          `LS_ADDR_RX_FINE:  rx_fine <= reg_req.wdata;
          `LS_ADDR_TX_FINE:  tx_fine <= reg_req.wdata;
          default:           ;
        endcase
      end
      // Period exact only after two ticks at the new rate
      if (reg_req.wr && (reg_req.addr == `LS_ADDR_BAUD || reg_req.addr == `LS_ADDR_TX_FINE)) begin
        settle <= 2'd0;
      end else if (tx_bit_tick && settle != 2'd2) begin
        settle <= settle + 2'd1;
      end
    end
  end

  always_comb begin
    case (baud[7:6])
      2'd0:    pr = 1;
      2'd1:    pr = 3;
      2'd2:    pr = 4;
      default: pr = 13;
    endcase
    exp_gap = 16 * pr * (1 << baud[5:3]) * ((tx_fine == 8'h00) ? 1 : int'(tx_fine));
  end

  AST_RD_IDLE_ZERO: assert property (!reg_req.rd |=> rd_data == 8'h00)
    else $error("read data not zero outside read cycle");
  AST_TX_TICK_PULSE: assert property (tx_bit_tick |=> !tx_bit_tick)
    else $error("tx bit tick longer than one cycle");
  AST_TX_PERIOD: assert property (tx_bit_tick && settle == 2'd2 |-> gap == exp_gap)
    else $error("tx bit period wrong");
  AST_RESET_QUIET: assert property (first |-> !rx_irq && !parity_irq && !tx_bit_tick)
    else $error("outputs active after reset");
  AST_RX_IRQ_ENABLED: assert property (rx_irq |-> c2[5] || c2[4] || $past(c2[5] || c2[4]))
    else $error("receive request without enable");
  AST_PARITY_IRQ_ENABLED: assert property (parity_irq |-> c1[0] || $past(c1[0]))
    else $error("parity request without enable");
  AST_STATUS_TOP: assert property (reg_req.rd && reg_req.addr == `LS_ADDR_STATUS
    |=> rd_data[7:6] == 2'b11)
    else $error("status top bits not set");
  AST_BAUD_READBACK: assert property (reg_req.rd && reg_req.addr == `LS_ADDR_BAUD
    |=> rd_data == baud)
    else $error("baud select readback wrong");
  AST_RX_FINE_READBACK: assert property (reg_req.rd && reg_req.addr == `LS_ADDR_RX_FINE
    |=> rd_data == rx_fine)
    else $error("rx fine divisor readback wrong");
  AST_TX_FINE_READBACK: assert property (reg_req.rd && reg_req.addr == `LS_ADDR_TX_FINE
    |=> rd_data == tx_fine)
    else $error("tx fine divisor readback wrong");

  cover property ($rose(parity_irq));
  cover property ($rose(rx_irq));
  cover property (tx_bit_tick && settle == 2'd2 && baud[7:6] == 2'd3);
  cover property ($fell(rxd) ##1 !rxd [*8]);
endmodule

bind lin_sci_receiver lin_sci_receiver_props u_props (.ref_clk(ref_clk), .rst(rst),
  .reg_req(reg_req), .rd_data(rd_data), .rxd(rxd), .tx_bit_tick(tx_bit_tick),
  .rx_irq(rx_irq), .parity_irq(parity_irq));

// *** dv/lin_sci_receiver_baud_and_errors_tb.sv ***
// Self-checking bench for the LIN serial receiver
`timescale 1ns/100ps
`include "lin_sci_params.svh"
module lin_sci_receiver_baud_and_errors_tb;
  import lin_sci_pkg::*;
  localparam int BIT = 16;
  logic       ref_clk, rst, rxd, tx_bit_tick, rx_irq, parity_irq;
  reg_req_t   reg_req;
  logic [7:0] rd_data, seen;
  int         miscompares, check_count, cycles, i;
  int         prs[4] = '{1, 3, 4, 13};

  lin_sci_receiver uut (.ref_clk(ref_clk), .rst(rst), .reg_req(reg_req), .rd_data(rd_data),
    .rxd(rxd), .tx_bit_tick(tx_bit_tick), .rx_irq(rx_irq), .parity_irq(parity_irq));
  lin_bus_node node (.ref_clk(ref_clk), .rxd(rxd));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Extra edge at the end keeps back-to-back calls from double assignment
  task automatic wr(input logic [2:0] addr, input logic [7:0] data);
    reg_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    reg_req.wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [2:0] addr, output logic [7:0] data);
    reg_req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    reg_req.rd <= 1'b0;
    @(posedge ref_clk);
    data = rd_data;
  endtask

  task automatic rchk(input logic [2:0] addr, input logic [7:0] exp, input logic [7:0] mask);
    logic [7:0] d;
    rd(addr, d);
    check(d & mask, exp);
  endtask

  // Status access then data read
  task automatic clr();
    rd(`LS_ADDR_STATUS, seen);
    rd(`LS_ADDR_DATA, seen);
  endtask

  task automatic send(input logic [7:0] value, input logic stop);
    node.send_char(value, stop, BIT);
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard, about two and a half times the expected run
  initial begin
    cycles = 0;
    forever begin
      @(posedge ref_clk);
      cycles++;
      if (cycles == 30000) begin
        miscompares++;
        end_of_test();
      end
    end
  end

  initial begin
    reg_req = '0;
    rst = 1'b1;
    miscompares = 0;
    check_count = 0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rchk(`LS_ADDR_STATUS, 8'hC0, 8'hFF);
    rchk(`LS_ADDR_RX_FINE, 8'h00, 8'hFF);
    rchk(`LS_ADDR_TX_FINE, 8'h00, 8'hFF);
    wr(`LS_ADDR_STATUS, 8'h3F);
    rchk(`LS_ADDR_STATUS, 8'hC0, 8'hFF);
    // Rates change only while receiver is off
    wr(`LS_ADDR_TX_FINE, 8'h03);
    for (i = 0; i < 4; i++) begin
      wr(`LS_ADDR_BAUD, {i[1:0], 6'h08});
      rchk(`LS_ADDR_BAUD, {i[1:0], 6'h08}, 8'hFF);
      repeat (4 * 96 * prs[i]) @(posedge ref_clk);
    end
    wr(`LS_ADDR_BAUD, 8'h00);
    wr(`LS_ADDR_TX_FINE, 8'h00);
    wr(`LS_ADDR_CTRL_TWO, 8'h24);
    send(8'hA5, 1'b1);
    rchk(`LS_ADDR_STATUS, 8'hE0, 8'hEF);
    check({7'h00, rx_irq}, 8'h01);
    rchk(`LS_ADDR_DATA, 8'hA5, 8'hFF);
    send(8'h3C, 1'b1);
    send(8'h5A, 1'b1);
    rchk(`LS_ADDR_STATUS, 8'hE8, 8'hEF);
    rchk(`LS_ADDR_DATA, 8'h3C, 8'hFF);
    rchk(`LS_ADDR_STATUS, 8'hC0, 8'hEF);
    // LIN slave header with a bad identifier parity
    wr(`LS_ADDR_LIN_CTRL, 8'hC0);
    wr(`LS_ADDR_CTRL_ONE, 8'h05);
    node.send_break(BIT);
    rchk(`LS_ADDR_STATUS, 8'h00, 8'h02);
    rd(`LS_ADDR_DATA, seen);
    rchk(`LS_ADDR_LIN_CTRL, 8'hC1, 8'hFF);
    send(8'h55, 1'b1);
    clr();
    send(8'h00, 1'b1);
    rchk(`LS_ADDR_STATUS, 8'h01, 8'h0B);
    check({7'h00, parity_irq}, 8'h01);
    rd(`LS_ADDR_DATA, seen);
    rchk(`LS_ADDR_STATUS, 8'h00, 8'h01);
    check({7'h00, parity_irq}, 8'h00);
    // Corrupt sync field locks the header
    node.send_break(BIT);
    clr();
    send(8'h33, 1'b1);
    rchk(`LS_ADDR_LIN_CTRL, 8'h02, 8'h02);
    rchk(`LS_ADDR_STATUS, 8'h08, 8'h08);
    check({7'h00, rx_irq}, 8'h01);
    clr();
    rchk(`LS_ADDR_STATUS, 8'h08, 8'h08);
    check({7'h00, rx_irq}, 8'h01);
    wr(`LS_ADDR_LIN_CTRL, 8'hC0);
    clr();
    rchk(`LS_ADDR_STATUS, 8'h00, 8'h08);
    // Header never completes
    node.send_break(BIT);
    clr();
    repeat (50 * BIT) @(posedge ref_clk);
    rchk(`LS_ADDR_STATUS, 8'h08, 8'h08);
    clr();
    send(8'h01, 1'b0);
    rchk(`LS_ADDR_STATUS, 8'h02, 8'h02);
    clr();
    // Mute with address mark wake
    wr(`LS_ADDR_LIN_CTRL, 8'h00);
    wr(`LS_ADDR_CTRL_ONE, 8'h08);
    wr(`LS_ADDR_CTRL_TWO, 8'h26);
    send(8'h12, 1'b1);
    rchk(`LS_ADDR_STATUS, 8'hC0, 8'hFF);
    check({7'h00, rx_irq}, 8'h00);
    send(8'h92, 1'b1);
    rchk(`LS_ADDR_CTRL_TWO, 8'h24, 8'hFF);
    rchk(`LS_ADDR_STATUS, 8'hE0, 8'hEF);
    rchk(`LS_ADDR_DATA, 8'h92, 8'hFF);
    // Mute with idle line wake
    wr(`LS_ADDR_CTRL_ONE, 8'h00);
    wr(`LS_ADDR_CTRL_TWO, 8'h26);
    send(8'h12, 1'b1);
    repeat (12 * BIT) @(posedge ref_clk);
    rchk(`LS_ADDR_CTRL_TWO, 8'h24, 8'hFF);
    rchk(`LS_ADDR_STATUS, 8'hC0, 8'hFF);
    // Slower receive rate: power-of-two two and fine divisor two
    wr(`LS_ADDR_CTRL_TWO, 8'h00);
    wr(`LS_ADDR_BAUD, 8'h01);
    wr(`LS_ADDR_RX_FINE, 8'h02);
    wr(`LS_ADDR_CTRL_TWO, 8'h24);
    node.send_char(8'hC3, 1'b1, 4 * BIT);
    repeat (4) @(posedge ref_clk);
    rchk(`LS_ADDR_STATUS, 8'hE0, 8'hEF);
    rchk(`LS_ADDR_DATA, 8'hC3, 8'hFF);
    end_of_test();
  end
endmodule
